// File: core/ldc_defs.svh
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// register offsets on the serial link
`define LDC_ADDR_KEYPAD_CEIL 8'h02
`define LDC_ADDR_BL_CTRL 8'h03
`define LDC_ADDR_PRI_CUR 8'h04
`define LDC_ADDR_SEC_CUR 8'h05
`define LDC_ADDR_PIN_CTRL 8'h06
`define LDC_ADDR_PIN_DATA 8'h07

// writable bits of each register; all others read as zero
`define LDC_RW_KEYPAD_CEIL 8'h3F
`define LDC_RW_BL_CTRL 8'h3F
`define LDC_RW_CUR 8'hFF
`define LDC_RW_PIN_CTRL 8'h17
`define LDC_RW_PIN_DATA 8'h07
`define LDC_RST_VAL 8'h00

// field positions
`define LDC_KP1_POS 4
`define LDC_KP2_POS 2
`define LDC_KP3_POS 0
`define LDC_FADE_DURATION_SELECT_BIT 5
`define LDC_FADE_SEL_BIT 4
`define LDC_FADE_EN_BIT 3
`define LDC_GANG_BIT 2
`define LDC_PRI_EN_BIT 1
`define LDC_SEC_EN_BIT 0
`define LDC_PWM_PIN_EN_BIT 4

// timing: full-scale fade spread over 255 code steps
`define LDC_CLK_HZ 10000000
`define LDC_FADE_FAST_MS 650
`define LDC_FADE_SLOW_MS 1300
`define LDC_FULL_SCALE 255
`define LDC_FADE_FAST_CYC (`LDC_FADE_FAST_MS * (`LDC_CLK_HZ / 1000) / `LDC_FULL_SCALE)
`define LDC_FADE_SLOW_CYC (`LDC_FADE_SLOW_MS * (`LDC_CLK_HZ / 1000) / `LDC_FULL_SCALE)

// serial slave address, value arbitrary
`define LDC_DEV_ADDR 7'h2A

`endif

// File: core/ldc_pkg.sv
package ldc_pkg;

  typedef enum logic [8:0] {
    LDC_IDLE = 9'h001,
    LDC_ADDR = 9'h002,
    LDC_ACK_ADDR = 9'h004,
    LDC_REG = 9'h008,
    LDC_ACK_REG = 9'h010,
    LDC_WDATA = 9'h020,
    LDC_ACK_W = 9'h040,
    LDC_RDATA = 9'h080,
    LDC_ACK_R = 9'h100
  } ldc_link_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ldc_wr_s;

endpackage

// File: core/ldc_link_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defs.svh"

module ldc_link_slave #(
  parameter logic [6:0] DEV_ADDR = `LDC_DEV_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] reg_ptr_o,
  output ldc_pkg::ldc_wr_s wr_o
);
  import ldc_pkg::*;

  ldc_link_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift, next_ptr;
  logic scl_q, sda_q, rw, next_rw, mack, next_mack, next_oe;
  ldc_wr_s next_wr;
  logic scl_rise, scl_fall, start_c, stop_c;

  always_comb begin
    scl_rise = scl_i & ~scl_q;
    scl_fall = ~scl_i & scl_q;
    start_c = scl_i & scl_q & sda_q & ~sda_i;
    stop_c = scl_i & scl_q & ~sda_q & sda_i;
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = reg_ptr_o;
    next_rw = rw;
    next_mack = mack;
    next_oe = sda_oe_o;
    next_wr = '0;
    if (start_c) begin
      next_state = LDC_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_c) begin
      next_state = LDC_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        LDC_ADDR, LDC_REG, LDC_WDATA: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_i};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_oe = 1'b1;
            if (state == LDC_ADDR) begin
              if (shift[7:1] == DEV_ADDR) begin
                next_rw = shift[0];
                next_state = LDC_ACK_ADDR;
              end else begin
                next_oe = 1'b0;
                next_state = LDC_IDLE;
              end
            end else if (state == LDC_REG) begin
              next_ptr = shift;
              next_state = LDC_ACK_REG;
            end else begin
              // field update happens as the byte is acknowledged
              next_wr = '{valid: 1'b1, addr: reg_ptr_o, data: shift};
              next_ptr = reg_ptr_o + 8'h01;
              next_state = LDC_ACK_W;
            end
          end
        end
        LDC_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw) begin
              next_shift = rd_data_i;
              next_oe = ~rd_data_i[7];
              next_state = LDC_RDATA;
            end else begin
              next_oe = 1'b0;
              next_state = LDC_REG;
            end
          end
        end
        LDC_ACK_REG, LDC_ACK_W: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = LDC_WDATA;
          end
        end
        LDC_RDATA: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_oe = 1'b0;
              next_ptr = reg_ptr_o + 8'h01;
              next_state = LDC_ACK_R;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_oe = ~shift[6];
            end
          end
        end
        LDC_ACK_R: begin
          if (scl_rise) begin
            next_mack = ~sda_i;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (mack) begin
              next_shift = rd_data_i;
              next_oe = ~rd_data_i[7];
              next_state = LDC_RDATA;
            end else begin
              next_state = LDC_IDLE;
            end
          end
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= LDC_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      reg_ptr_o <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wr_o <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      reg_ptr_o <= next_ptr;
      rw <= next_rw;
      mack <= next_mack;
      sda_oe_o <= next_oe;
      sda_o <= 1'b0;
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_o <= next_wr;
    end
  end

endmodule // ldc_link_slave

`default_nettype wire

// File: core/ldc_led_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defs.svh"

module ldc_led_regs #(
  parameter int FADE_FAST_CYC = `LDC_FADE_FAST_CYC,
  parameter int FADE_SLOW_CYC = `LDC_FADE_SLOW_CYC,
  parameter logic [6:0] DEV_ADDR = `LDC_DEV_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic pwm_pin_i,
  input wire logic [2:0] gpio_i,
  output logic [2:0] gpio_o,
  output logic [2:0] gpio_oe_o,
  output logic [1:0] keypad_one_ceiling_o,
  output logic [1:0] keypad_two_ceiling_o,
  output logic [1:0] keypad_three_ceiling_o,
  output logic [7:0] primary_current_o,
  output logic [7:0] secondary_current_o,
  output logic pwm_gate_o
);
  import ldc_pkg::*;

  ldc_wr_s wr;
  logic [7:0] reg_ptr, rd_data;
  logic [7:0] kp, ctrl, pri, sec, pctl, pdat;
  logic [7:0] next_kp, next_ctrl, next_pri, next_sec, next_pctl, next_pdat;
  logic [7:0] lvl_p, lvl_s, next_lvl_p, next_lvl_s, tgt_p, tgt_s;
  logic [7:0] next_pri_o, next_sec_o;
  logic [2:0] next_gpio_o, next_gpio_oe;
  logic next_pwm_gate, fade_p, fade_s;
  logic [15:0] div_cnt, next_div, step_lim;
  logic step_en, next_step;

  // masked write keeps read-only positions at zero
  function automatic logic [7:0] wr_field(input logic [7:0] cur, input ldc_wr_s w,
                                          input logic [7:0] addr, input logic [7:0] mask);
    wr_field = (w.valid && w.addr == addr) ? (w.data & mask) : cur;
  endfunction

  function automatic logic [7:0] approach(input logic [7:0] lvl, input logic [7:0] tgt);
    if (lvl < tgt) begin
      approach = lvl + 8'h01;
    end else if (lvl > tgt) begin
      approach = lvl - 8'h01;
    end else begin
      approach = lvl;
    end
  endfunction

  ldc_link_slave #(.DEV_ADDR(DEV_ADDR)) u_link (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .rd_data_i(rd_data),
    .reg_ptr_o(reg_ptr),
    .wr_o(wr)
  );

  // register file
  always_comb begin
    next_kp = wr_field(kp, wr, `LDC_ADDR_KEYPAD_CEIL, `LDC_RW_KEYPAD_CEIL);
    next_ctrl = wr_field(ctrl, wr, `LDC_ADDR_BL_CTRL, `LDC_RW_BL_CTRL);
    next_pri = wr_field(pri, wr, `LDC_ADDR_PRI_CUR, `LDC_RW_CUR);
    next_sec = wr_field(sec, wr, `LDC_ADDR_SEC_CUR, `LDC_RW_CUR);
    next_pctl = wr_field(pctl, wr, `LDC_ADDR_PIN_CTRL, `LDC_RW_PIN_CTRL);
    next_pdat = wr_field(pdat, wr, `LDC_ADDR_PIN_DATA, `LDC_RW_PIN_DATA);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      kp <= `LDC_RST_VAL;
      ctrl <= `LDC_RST_VAL;
      pri <= `LDC_RST_VAL;
      sec <= `LDC_RST_VAL;
      pctl <= `LDC_RST_VAL;
      pdat <= `LDC_RST_VAL;
    end else begin
      kp <= next_kp;
      ctrl <= next_ctrl;
      pri <= next_pri;
      sec <= next_sec;
      pctl <= next_pctl;
      pdat <= next_pdat;
    end
  end

  // input-configured pins read back their live level, outputs the stored bit
  always_comb begin
    case (reg_ptr)
      `LDC_ADDR_KEYPAD_CEIL: rd_data = kp;
      `LDC_ADDR_BL_CTRL: rd_data = ctrl;
      `LDC_ADDR_PRI_CUR: rd_data = pri;
      `LDC_ADDR_SEC_CUR: rd_data = sec;
      `LDC_ADDR_PIN_CTRL: rd_data = pctl;
      `LDC_ADDR_PIN_DATA: rd_data = {5'h00, (pdat[2:0] & pctl[2:0]) | (gpio_i & ~pctl[2:0])};
      default: rd_data = 8'h00;
    endcase
  end

  assign keypad_one_ceiling_o = kp[`LDC_KP1_POS +: 2];
  assign keypad_two_ceiling_o = kp[`LDC_KP2_POS +: 2];
  assign keypad_three_ceiling_o = kp[`LDC_KP3_POS +: 2];

  // fade step divider; one code step per tick, so 255 ticks per full scale
  always_comb begin
    step_lim = ctrl[`LDC_FADE_DURATION_SELECT_BIT] ? 16'(FADE_SLOW_CYC) : 16'(FADE_FAST_CYC);
    next_step = (div_cnt >= step_lim - 16'h0001);
    next_div = next_step ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div_cnt <= 16'h0000;
      step_en <= 1'b0;
    end else begin
      div_cnt <= next_div;
      step_en <= next_step;
    end
  end

  // backlight levels and outputs
  always_comb begin
    fade_p = ctrl[`LDC_FADE_EN_BIT] & ~ctrl[`LDC_FADE_SEL_BIT];
    fade_s = ctrl[`LDC_FADE_EN_BIT] & ctrl[`LDC_FADE_SEL_BIT];
    tgt_p = pri;
    tgt_s = ctrl[`LDC_GANG_BIT] ? pri : sec;
    next_lvl_p = fade_p ? (step_en ? approach(lvl_p, tgt_p) : lvl_p) : tgt_p;
    next_lvl_s = fade_s ? (step_en ? approach(lvl_s, tgt_s) : lvl_s) : tgt_s;
    // the code is the driver setting itself, 0.1 mA per count
    next_pri_o = ctrl[`LDC_PRI_EN_BIT] ? next_lvl_p : 8'h00;
    next_sec_o = ctrl[`LDC_SEC_EN_BIT] ? next_lvl_s : 8'h00;
    next_gpio_oe = pctl[2:0];
    next_gpio_o = pdat[2:0];
    next_pwm_gate = pctl[`LDC_PWM_PIN_EN_BIT] & pwm_pin_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lvl_p <= 8'h00;
      lvl_s <= 8'h00;
      primary_current_o <= 8'h00;
      secondary_current_o <= 8'h00;
      gpio_oe_o <= 3'h0;
      gpio_o <= 3'h0;
      pwm_gate_o <= 1'b0;
    end else begin
      lvl_p <= next_lvl_p;
      lvl_s <= next_lvl_s;
      primary_current_o <= next_pri_o;
      secondary_current_o <= next_sec_o;
      gpio_oe_o <= next_gpio_oe;
      gpio_o <= next_gpio_o;
      pwm_gate_o <= next_pwm_gate;
    end
  end

  // helper for the step period check: cycles since last tick, valid only
  // while the fade_duration_select setting has not moved since that tick
  logic [15:0] gap;
  logic armed;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gap <= 16'h0000;
      armed <= 1'b0;
    end else begin
      gap <= step_en ? 16'h0001 : gap + 16'h0001;
      armed <= (next_ctrl[`LDC_FADE_DURATION_SELECT_BIT] != ctrl[`LDC_FADE_DURATION_SELECT_BIT]) ? 1'b0 : (armed | step_en);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_keypad_write;
    (wr.valid && wr.addr == `LDC_ADDR_KEYPAD_CEIL) |=>
      ({keypad_one_ceiling_o, keypad_two_ceiling_o, keypad_three_ceiling_o} == $past(wr.data[5:0]));
  endproperty
  a_keypad_write: assert property (p_keypad_write)
    else $error("keypad ceiling field not taken from written byte");

  property p_reserved_zero;
    (reg_ptr == `LDC_ADDR_PIN_CTRL) |-> (rd_data[7:5] == 3'h0 && rd_data[3] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("read-only pin control bit reads nonzero");

  property p_ctrl_mask;
    (wr.valid && wr.addr == `LDC_ADDR_BL_CTRL) |=> (ctrl == ($past(wr.data) & `LDC_RW_BL_CTRL));
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask)
    else $error("control write did not mask read-only bits");

  property p_step_period;
    (step_en && armed) |-> (gap == step_lim);
  endproperty
  a_step_period: assert property (p_step_period)
    else $error("fade step spacing wrong for fade_duration_select setting");

  property p_immediate;
    (!fade_p && ctrl[`LDC_PRI_EN_BIT]) |=> (primary_current_o == $past(pri));
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("primary output did not jump to new code");

  property p_ramp;
    fade_p |=> (lvl_p == $past(lvl_p) || lvl_p == $past(lvl_p) + 8'h01 || lvl_p == $past(lvl_p) - 8'h01);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("fading level moved by more than one step");

  property p_gang;
    (ctrl[`LDC_GANG_BIT] && !fade_s && ctrl[`LDC_SEC_EN_BIT]) |=> (secondary_current_o == $past(pri));
  endproperty
  a_gang: assert property (p_gang)
    else $error("ganged secondary output not following primary code");

  property p_pri_off;
    !ctrl[`LDC_PRI_EN_BIT] |=> (primary_current_o == 8'h00);
  endproperty
  a_pri_off: assert property (p_pri_off)
    else $error("disabled primary output not off");

  property p_sec_off;
    !ctrl[`LDC_SEC_EN_BIT] |=> (secondary_current_o == 8'h00);
  endproperty
  a_sec_off: assert property (p_sec_off)
    else $error("disabled secondary output not off");

  property p_pwm_gate;
    !pctl[`LDC_PWM_PIN_EN_BIT] |=> !pwm_gate_o;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate)
    else $error("external PWM pin passed while disabled");

  property p_gpio;
    ##1 (gpio_oe_o == $past(pctl[2:0]) && gpio_o == $past(pdat[2:0]));
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("general pin direction or level not from registers");

  c_fade_done: cover property ((fade_p && step_en && lvl_p != tgt_p) ##1 (lvl_p == tgt_p));
  c_gang: cover property (ctrl[`LDC_GANG_BIT] && ctrl[`LDC_SEC_EN_BIT] && pri != 8'h00);
  c_write: cover property (wr.valid && wr.addr == `LDC_ADDR_PRI_CUR);

endmodule // ldc_led_regs

`default_nettype wire

// File: sim/ldc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module ldc_host_model #(
  parameter int HALF = 4
) (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // also serves as repeated start, entered with the clock low
  task automatic start_cond();
    sda_low_o = 1'b0;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_low_o = 1'b1;
    tick(HALF);
    scl_o = 1'b0;
    tick(HALF);
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_low_o = 1'b0;
    tick(HALF);
  endtask

  // data held over the whole high phase, sampled at its last edge
  task automatic xfer_bit(input logic b, output logic r);
    sda_low_o = ~b;
    tick(HALF);
    scl_o = 1'b1;
    repeat (HALF) @(posedge core_clk_i);
    // sample after the edge settles so a flop launched on it cannot race the read
    #1;
    r = sda_i;
    scl_o = 1'b0;
    tick(HALF);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, d[i]);
    end
    xfer_bit(~more, r);
  endtask
endmodule // ldc_host_model

`default_nettype wire

// File: sim/ldc_led_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defs.svh"

module ldc_led_regs_tb;
  import ldc_pkg::*;
  logic core_clk_i, rst_i, pwm_pin_i, scl, sda_low, sda_oe, sda_val, pwm_gate;
  logic [2:0] gpio_i, gpio_o, gpio_oe;
  logic [1:0] kp1, kp2, kp3;
  logic [7:0] pri, sec;
  wire logic sda_line;
  int err_count = 0;
  int comparisons = 0;

  // open-drain data line with pull-up; the device value only counts while it is enabled
  assign sda_line = ~sda_low & (sda_oe ? sda_val : 1'b1);

  ldc_led_regs #(.FADE_FAST_CYC(8), .FADE_SLOW_CYC(16)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_val), .sda_oe_o(sda_oe), .pwm_pin_i(pwm_pin_i), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .keypad_one_ceiling_o(kp1),
    .keypad_two_ceiling_o(kp2), .keypad_three_ceiling_o(kp3),
    .primary_current_o(pri), .secondary_current_o(sec), .pwm_gate_o(pwm_gate)
  );

  ldc_host_model host (
    .core_clk_i(core_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send_chk(input logic [7:0] d);
    logic ack;
    host.send_byte(d, ack);
    check("ack", {7'h00, ack}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b0});
    send_chk(a);
    send_chk(d);
    host.stop_cond();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b0});
    send_chk(a);
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b1});
    host.recv_byte(1'b0, d);
    host.stop_cond();
  endtask

  task automatic t_reset();
    logic [7:0] d;
    for (int i = 2; i < 8; i++) begin
      rd(8'(i), d);
      check("reg_after_reset", d, 8'h00);
    end
    check("pri_after_reset", pri, 8'h00);
    check("oe_after_reset", {5'h00, gpio_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_masks();
    logic [7:0] m[6] = '{8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h17, 8'h07};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      wr(8'(i + 2), 8'hFF);
      rd(8'(i + 2), d);
      check("masked_readback", d, m[i]);
    end
    check("dir_out", {5'h00, gpio_oe}, 8'h07);
    check("pin_level", {5'h00, gpio_o}, 8'h07);
    wr(8'h02, 8'h1B);
    check("keypad_one", {6'h00, kp1}, 8'h01);
    check("keypad_two", {6'h00, kp2}, 8'h02);
    check("keypad_three", {6'h00, kp3}, 8'h03);
    $display("test masks done");
  endtask

  task automatic t_currents();
    logic [7:0] c[4] = '{8'h03, 8'h07, 8'h01, 8'h02};
    logic [7:0] ep[4] = '{8'h3A, 8'h3A, 8'h00, 8'h3A};
    logic [7:0] es[4] = '{8'hC5, 8'h3A, 8'hC5, 8'h00};
    wr(8'h03, 8'h03);
    wr(8'h04, 8'h3A);
    wr(8'h05, 8'hC5);
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, c[i]);
      check("primary", pri, ep[i]);
      check("secondary", sec, es[i]);
    end
    $display("test currents done");
  endtask

  task automatic t_fade(input logic [7:0] ctl, a, from, to, input int lo, hi);
    int n;
    logic [7:0] lvl;
    wr(8'h03, ctl & 8'hF7);
    wr(a, from);
    wr(8'h03, ctl);
    wr(a, to);
    n = 0;
    lvl = (a == 8'h04) ? pri : sec;
    check("fade_pending", {7'h00, lvl !== to}, 8'h01);
    while (lvl !== to && n < 300) begin
      @(posedge core_clk_i);
      #1;
      n++;
      lvl = (a == 8'h04) ? pri : sec;
    end
    if (n >= 300) begin
      err_count++;
      $display("unexpected fade_wait expected target seen timeout");
    end
    check("fade_time", {7'h00, n >= lo && n <= hi}, 8'h01);
    $display("test fade %h done", ctl);
  endtask

  task automatic t_pins();
    logic [7:0] d;
    wr(8'h06, 8'h00);
    check("dir_in", {5'h00, gpio_oe}, 8'h00);
    gpio_i = 3'h4;
    pwm_pin_i = 1'b1;
    host.tick(3);
    check("pwm_ignored", {7'h00, pwm_gate}, 8'h00);
    wr(8'h06, 8'h12);
    check("dir_mixed", {5'h00, gpio_oe}, 8'h02);
    check("pwm_passed", {7'h00, pwm_gate}, 8'h01);
    wr(8'h07, 8'h07);
    check("pin_level", {5'h00, gpio_o}, 8'h07);
    rd(8'h07, d);
    check("pin_readback", d, 8'h06);
    pwm_pin_i = 1'b0;
    host.tick(3);
    check("pwm_low", {7'h00, pwm_gate}, 8'h00);
    $display("test pins done");
  endtask

  // multi-byte write and read: offset steps by one per byte, master ack continues
  task automatic t_burst();
    logic [7:0] d0, d1;
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b0});
    send_chk(8'h04);
    send_chk(8'h11);
    send_chk(8'h22);
    host.stop_cond();
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b0});
    send_chk(8'h04);
    host.start_cond();
    send_chk({`LDC_DEV_ADDR, 1'b1});
    host.recv_byte(1'b1, d0);
    host.recv_byte(1'b0, d1);
    host.stop_cond();
    check("burst_first", d0, 8'h11);
    check("burst_second", d1, 8'h22);
    $display("test burst done");
  endtask

  task automatic t_refuse();
    logic [7:0] d;
    logic ack;
    host.start_cond();
    host.send_byte({`LDC_DEV_ADDR, 1'b0}, ack);
    host.send_byte(8'h08, ack);
    host.send_byte(8'h5A, ack);
    host.stop_cond();
    rd(8'h08, d);
    check("unmapped", d, 8'h00);
    host.start_cond();
    host.send_byte({~`LDC_DEV_ADDR, 1'b0}, ack);
    check("foreign_nack", {7'h00, ack}, 8'h00);
    host.stop_cond();
    rd(8'h02, d);
    check("keypad_kept", d, 8'h1B);
    $display("test refuse done");
  endtask

  initial begin
    rst_i = 1'b1;
    pwm_pin_i = 1'b0;
    gpio_i = 3'h0;
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_masks();
    t_currents();
    t_fade(8'h0A, 8'h04, 8'h00, 8'h08, 30, 68);
    t_fade(8'h2A, 8'h04, 8'h08, 8'h00, 72, 132);
    t_fade(8'h19, 8'h05, 8'h00, 8'h08, 30, 68);
    t_pins();
    t_burst();
    t_refuse();
    print_verdict();
  end
endmodule // ldc_led_regs_tb

`default_nettype wire
